// ### rtl/quadrature_decoder.sv
// How it works
// [RULE1] Sample both phases once per sample period.
// [RULE2] Decode each pair against the previous pair.
// [RULE3] No change gives 0; forward steps count up.
// [RULE4] Reverse steps give -1 and count down.
// [RULE5] Both phases changed: 2, count doubles.
// [RULE6] Change period only after stop and stopped.
// [RULE7] Change other settings preferably while stopped.
// [RULE8] LED on lead time before sample, then off.
// [RULE9] LED active level set by polarity.
// [RULE10] Disconnected LED pin is never driven.
// [RULE11] Each phase has its own optional filter.
// [RULE12] Filters sample at 1 MHz all period long.
// [RULE13] Filter passes level only if all samples equal.
// [RULE14] Long steady passes, short steady is suppressed.
// [RULE15] LED stays on while filters are enabled.
// [RULE16] Filtering delays displacement by one period.
// [RULE17] Overflowing steps are dropped with overflow event.
// [RULE18] Step register updates every period after start.
// [RULE19] Reset clears history, totals; LED inactive. Code resets ledOut low, the active level for reset polarity 0, with ledOe low.
`timescale 1ns/100ps
`include "quadrature_decoder_regs.svh"
module quadrature_decoder (
   input wire logic sys_clk, // System clock, 100 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic clkEn, // Clock enable; all state holds while low.
   input wire quadrature_decoder_pkg::apbAddr_t paddr, // APB address.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB write.
   input wire quadrature_decoder_pkg::word_t pwdata, // APB write data.
   output quadrature_decoder_pkg::word_t prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic phaseA, // Encoder phase A pin.
   input wire logic phaseB, // Encoder phase B pin.
   output logic ledOut, // LED pin level.
   output logic ledOe, // LED pin output enable.
   output logic irq // Level interrupt.
);
   import quadrature_decoder_pkg::*;

   localparam logic [`QD_TICK_W-1:0] TICK_LAST = `QD_TICK_W'(`QD_TICK_CYCLES - 1);

   // Pin synchronisers: the first stage feeds only the second.
   logic [1:0] pinMeta_q, pinSync_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pinMeta_q <= 2'h0;
         pinSync_q <= 2'h0;
      end else if (clkEn) begin
         pinMeta_q <= {phaseA, phaseB};
         pinSync_q <= pinMeta_q;
      end
   end

   // Configuration and control.
   runState_t run_q, run_d;
   logic enable_q, enable_d, led_polarity_q, led_polarity_d, debounce_enable_q, debounce_enable_d, ledDisc_q, ledDisc_d;
   logic [`QD_PERIOD_W-1:0] period_q, period_d;
   logic [`QD_REPORT_W-1:0] report_period_q, report_period_d;
   logic [`QD_LEAD_W-1:0] lead_q, lead_d;
   logic [`QD_EV_W-1:0] evt_q, evt_d, mask_q, mask_d, evtSet;
   word_t prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
   logic wrDone, clrTotal, clrDbl, hit, stopEv;
   word_t rdVal;

   // Timing.
   logic [`QD_TICK_W-1:0] tickCnt_q, tickCnt_d;
   logic [`QD_US_W-1:0] usCnt_q, usCnt_d, periodUs, usLeft;
   logic tick, periodEnd;
   logic ledOut_q, ledOut_d, ledOe_q, ledOe_d;

   // Decoding and accumulation.
   logic [1:0] prev_q, prev_d, cur;
   step_t step_q, step_d, stepNow;
   logic signed [`QD_TOTAL_W-1:0] total_q, total_d, totalRd_q, totalRd_d, totalBase;
   logic signed [`QD_TOTAL_W:0] totalSum;
   logic [`QD_DBL_W-1:0] dbl_q, dbl_d, dblRd_q, dblRd_d, dblBase;
   logic [`QD_REPORT_W-1:0] repCnt_q, repCnt_d;
   logic filtA, filtB;

   debounce_filter filterA (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .enable(debounce_enable_q), // [RULE11]
      .tick(tick),
      .periodEnd(periodEnd),
      .din(pinSync_q[1]),
      .dout(filtA)
   );

   debounce_filter filterB (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .enable(debounce_enable_q), // [RULE11]
      .tick(tick),
      .periodEnd(periodEnd),
      .din(pinSync_q[0]),
      .dout(filtB)
   );

   // One wait state: pready rises in the second access cycle, and a write lands with it.
   assign wrDone = psel && penable && pready_q && pwrite;

   // Read multiplexer; task registers and unmapped addresses read zero.
   always_comb begin
      hit = 1'b1;
      rdVal = 32'h0;
      case (paddr)
         `QD_OFS_START, `QD_OFS_STOP, `QD_OFS_RDCLR_BOTH, `QD_OFS_RDCLR_TOTAL, `QD_OFS_RDCLR_DBL: rdVal = 32'h0;
         `QD_OFS_EVENTS: rdVal = 32'(evt_q);
         `QD_OFS_INTMASK: rdVal = 32'(mask_q);
         `QD_OFS_STATUS: rdVal = 32'(run_q == RS_RUNNING);
         `QD_OFS_ENABLE: rdVal = 32'(enable_q);
         `QD_OFS_LED_POLARITY: rdVal = 32'(led_polarity_q);
         `QD_OFS_PERIOD: rdVal = 32'(period_q);
         `QD_OFS_STEP: rdVal = 32'(signed'(step_q));
         `QD_OFS_REPORT: rdVal = 32'(report_period_q);
         `QD_OFS_TOTAL: rdVal = 32'(total_q);
         `QD_OFS_TOTALREAD: rdVal = 32'(totalRd_q);
         `QD_OFS_LEDPIN: rdVal = {ledDisc_q, 31'h0};
         `QD_OFS_DEBOUNCE: rdVal = 32'(debounce_enable_q);
         `QD_OFS_LEADTIME: rdVal = 32'(lead_q);
         `QD_OFS_DBLCNT: rdVal = 32'(dbl_q);
         `QD_OFS_DBLREAD: rdVal = 32'(dblRd_q);
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      run_d = run_q;
      enable_d = enable_q;
      led_polarity_d = led_polarity_q;
      debounce_enable_d = debounce_enable_q;
      ledDisc_d = ledDisc_q;
      period_d = period_q;
      report_period_d = report_period_q;
      lead_d = lead_q;
      mask_d = mask_q;
      clrTotal = 1'b0;
      clrDbl = 1'b0;
      stopEv = 1'b0;
      pready_d = psel && penable && !pready_q;
      pslverr_d = psel && penable && !pready_q && !hit;
      prdata_d = (psel && penable && !pready_q && !pwrite) ? rdVal : 32'h0;
      if (wrDone) begin
         case (paddr)
            `QD_OFS_START: if (pwdata[0] && enable_q) run_d = RS_RUNNING;
            `QD_OFS_STOP: if (pwdata[0] && run_q == RS_RUNNING) begin
               run_d = RS_STOPPED;
               stopEv = 1'b1;
            end
            `QD_OFS_RDCLR_BOTH: begin
               clrTotal = pwdata[0];
               clrDbl = pwdata[0];
            end
            `QD_OFS_RDCLR_TOTAL: clrTotal = pwdata[0];
            `QD_OFS_RDCLR_DBL: clrDbl = pwdata[0];
            `QD_OFS_INTMASK: mask_d = pwdata[`QD_EV_W-1:0];
            `QD_OFS_ENABLE: begin
               // Clearing enable also stops the decoder, without a stopped event.
               enable_d = pwdata[0];
               if (!pwdata[0]) run_d = RS_STOPPED;
            end
            `QD_OFS_LED_POLARITY: led_polarity_d = pwdata[0];
            `QD_OFS_PERIOD: period_d = pwdata[`QD_PERIOD_W-1:0];
            `QD_OFS_REPORT: report_period_d = pwdata[`QD_REPORT_W-1:0];
            `QD_OFS_LEDPIN: ledDisc_d = pwdata[`QD_LEDPIN_DISC_BIT];
            `QD_OFS_DEBOUNCE: debounce_enable_d = pwdata[0];
            `QD_OFS_LEADTIME: lead_d = pwdata[`QD_LEAD_W-1:0];
            default: ;
         endcase
      end
   end

   // Timing: 1 MHz strobe and position inside the sample period.
   always_comb begin
      periodUs = `QD_US_W'(({7'h0, period_q} + 11'd1) * `QD_PERIOD_STEP_US);
      usLeft = periodUs - 11'd1 - usCnt_q;
      tick = (run_q == RS_RUNNING) && (tickCnt_q == TICK_LAST);
      periodEnd = tick && (usLeft == 11'd0); // [RULE1]
      tickCnt_d = tickCnt_q;
      usCnt_d = usCnt_q;
      // The counters restart on every start, so the first sample comes one full period later.
      if (run_q != RS_RUNNING) begin
         tickCnt_d = '0;
         usCnt_d = '0;
      end else if (tick) begin
         tickCnt_d = '0;
         usCnt_d = periodEnd ? 11'd0 : usCnt_q + 11'd1;
      end else begin
         tickCnt_d = tickCnt_q + `QD_TICK_W'(1);
      end
      ledOut_d = ~led_polarity_q;
      // The lead window closes at the sampling edge, when usLeft wraps back to a full period.
      if (run_q == RS_RUNNING && (debounce_enable_q || {2'h0, lead_q} > usLeft)) begin // [RULE8] [RULE15]
         ledOut_d = led_polarity_q; // [RULE9]
      end
      ledOe_d = enable_q && !ledDisc_q; // [RULE10]
   end

   // Decoding. With filters on, the filter output lags by one period.
   always_comb begin
      cur = debounce_enable_q ? {filtA, filtB} : pinSync_q; // [RULE16]
      stepNow = 3'sd0;
      if ((prev_q ^ cur) == 2'b11) begin
         stepNow = 3'sd2; // [RULE5]
      end else if (prev_q != cur) begin
         stepNow = (prev_q[1] ^ cur[0]) ? 3'sd1 : -3'sd1; // [RULE2] [RULE3] [RULE4]
      end
      prev_d = prev_q;
      step_d = step_q;
      repCnt_d = repCnt_q;
      totalBase = clrTotal ? '0 : total_q;
      dblBase = clrDbl ? '0 : dbl_q;
      totalRd_d = clrTotal ? total_q : totalRd_q;
      dblRd_d = clrDbl ? dbl_q : dblRd_q;
      total_d = totalBase;
      dbl_d = dblBase;
      totalSum = '0;
      evtSet = '0;
      evtSet[`QD_EV_STOPPED] = stopEv;
      if (periodEnd) begin
         prev_d = cur;
         step_d = stepNow; // [RULE18]
         evtSet[`QD_EV_SAMPLE] = 1'b1;
         // A double transition only counts doubles; a saturated count is refused as overflow.
         if (stepNow == 3'sd2) begin
            if (&dblBase) evtSet[`QD_EV_OVERFLOW] = 1'b1;
            else dbl_d = dblBase + `QD_DBL_W'(1); // [RULE5]
         end else if (stepNow != 3'sd0) begin
            totalSum = {totalBase[`QD_TOTAL_W-1], totalBase} + (`QD_TOTAL_W+1)'(stepNow);
            if (totalSum[`QD_TOTAL_W] != totalSum[`QD_TOTAL_W-1]) begin
               evtSet[`QD_EV_OVERFLOW] = 1'b1; // [RULE17]
            end else begin
               total_d = totalSum[`QD_TOTAL_W-1:0]; // [RULE3] [RULE4]
            end
         end
         // Report and double events look at the totals once per report period plus one samples.
         if (repCnt_q == report_period_q) begin
            repCnt_d = '0;
            evtSet[`QD_EV_REPORT] = (total_d != '0);
            evtSet[`QD_EV_DOUBLE] = (dbl_d != '0);
         end else begin
            repCnt_d = repCnt_q + `QD_REPORT_W'(1);
         end
      end
   end

   // A new event wins over a clear in the same cycle.
   always_comb begin
      evt_d = evt_q | evtSet;
      if (wrDone && paddr == `QD_OFS_EVENTS) begin
         evt_d = (evt_q & ~pwdata[`QD_EV_W-1:0]) | evtSet;
      end
      irq_d = |(evt_q & mask_q);
   end

   // Bus, control, configuration and event registers.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         run_q <= RS_STOPPED;
         enable_q <= 1'b0;
         led_polarity_q <= 1'b0;
         debounce_enable_q <= 1'b0;
         ledDisc_q <= `QD_LEDPIN_RST;
         period_q <= '0;
         report_period_q <= '0;
         lead_q <= `QD_LEAD_RST;
         mask_q <= '0;
         evt_q <= '0;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (clkEn) begin
         run_q <= run_d;
         enable_q <= enable_d;
         led_polarity_q <= led_polarity_d;
         debounce_enable_q <= debounce_enable_d;
         ledDisc_q <= ledDisc_d;
         period_q <= period_d;
         report_period_q <= report_period_d;
         lead_q <= lead_d;
         mask_q <= mask_d;
         evt_q <= evt_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q <= irq_d;
      end
   end

   // Sample timing and LED pin.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tickCnt_q <= '0;
         usCnt_q <= '0;
         ledOut_q <= 1'b0; // [RULE19]
         ledOe_q <= 1'b0;
      end else if (clkEn) begin
         tickCnt_q <= tickCnt_d;
         usCnt_q <= usCnt_d;
         ledOut_q <= ledOut_d;
         ledOe_q <= ledOe_d;
      end
   end

   // Decoder history and accumulators.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prev_q <= 2'h0; // [RULE19]
         step_q <= 3'sd0;
         total_q <= '0; // [RULE19]
         totalRd_q <= '0;
         dbl_q <= '0; // [RULE19]
         dblRd_q <= '0;
         repCnt_q <= '0;
      end else if (clkEn) begin
         prev_q <= prev_d;
         step_q <= step_d;
         total_q <= total_d;
         totalRd_q <= totalRd_d;
         dbl_q <= dbl_d;
         dblRd_q <= dblRd_d;
         repCnt_q <= repCnt_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ledOut = ledOut_q;
   assign ledOe = ledOe_q;
   assign irq = irq_q;
endmodule : quadrature_decoder

// ### inc/quadrature_decoder_regs.svh
`ifndef QUADRATURE_DECODER_REGS_SVH
`define QUADRATURE_DECODER_REGS_SVH
`define QD_OFS_START 12'h000
`define QD_OFS_STOP 12'h004
`define QD_OFS_RDCLR_BOTH 12'h008
`define QD_OFS_RDCLR_TOTAL 12'h00c
`define QD_OFS_RDCLR_DBL 12'h010
`define QD_OFS_EVENTS 12'h100
`define QD_OFS_INTMASK 12'h104
`define QD_OFS_STATUS 12'h108
`define QD_OFS_ENABLE 12'h500
`define QD_OFS_LED_POLARITY 12'h504
`define QD_OFS_PERIOD 12'h508
`define QD_OFS_STEP 12'h50c
`define QD_OFS_REPORT 12'h510
`define QD_OFS_TOTAL 12'h514
`define QD_OFS_TOTALREAD 12'h518
`define QD_OFS_LEDPIN 12'h51c
`define QD_OFS_DEBOUNCE 12'h528
`define QD_OFS_LEADTIME 12'h540
`define QD_OFS_DBLCNT 12'h544
`define QD_OFS_DBLREAD 12'h548
`define QD_EV_SAMPLE 0
`define QD_EV_REPORT 1
`define QD_EV_OVERFLOW 2
`define QD_EV_DOUBLE 3
`define QD_EV_STOPPED 4
`define QD_EV_W 5
`define QD_LEDPIN_DISC_BIT 31
`define QD_LEDPIN_RST 1'b1
`define QD_PERIOD_W 4
`define QD_PERIOD_STEP_US 11'd64
`define QD_LEAD_W 9
`define QD_LEAD_RST 9'h010
`define QD_REPORT_W 4
`define QD_TOTAL_W 16
`define QD_DBL_W 4
`define QD_CLK_PERIOD_NS 10
`define QD_FILTER_PERIOD_NS 1000
`define QD_TICK_CYCLES (`QD_FILTER_PERIOD_NS / `QD_CLK_PERIOD_NS)
`define QD_TICK_W 7
`define QD_US_W 11
`endif

// ### inc/quadrature_decoder_pkg.sv
package quadrature_decoder_pkg;
   typedef logic [11:0] apbAddr_t;
   typedef logic [31:0] word_t;
   typedef enum logic {RS_STOPPED, RS_RUNNING} runState_t;
   typedef logic signed [2:0] step_t;
endpackage : quadrature_decoder_pkg

// ### rtl/debounce_filter.sv
`timescale 1ns/100ps
`include "quadrature_decoder_regs.svh"
module debounce_filter (
   input wire logic sys_clk, // System clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic clkEn, // Freezes state while low.
   input wire logic enable, // Filter active.
   input wire logic tick, // 1 MHz filter sampling strobe.
   input wire logic periodEnd, // Last filter sample of the sample period.
   input wire logic din, // Synchronised phase level.
   output logic dout // Filtered phase level.
);
   logic cand_q, cand_d, same_q, same_d, first_q, first_d, out_q, out_d;

   always_comb begin
      cand_d = cand_q;
      same_d = same_q;
      first_d = first_q;
      out_d = out_q;
      if (!enable) begin
         first_d = 1'b1;
         out_d = din;
      end else if (tick) begin // [RULE12]
         if (first_q) begin
            cand_d = din;
            same_d = 1'b1;
            first_d = 1'b0;
         end else if (din != cand_q) begin
            same_d = 1'b0;
         end
         if (periodEnd) begin
            // Only a level held by every sample of the period is passed.
            if (!first_q && same_q && din == cand_q) begin
               out_d = cand_q; // [RULE13] [RULE14]
            end
            first_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cand_q <= 1'b0;
         same_q <= 1'b0;
         first_q <= 1'b1;
         out_q <= 1'b0;
      end else if (clkEn) begin
         cand_q <= cand_d;
         same_q <= same_d;
         first_q <= first_d;
         out_q <= out_d;
      end
   end

   assign dout = out_q;
endmodule : debounce_filter

// ### verif/quadrature_encoder_model.sv
`timescale 1ns/100ps
module quadrature_encoder_model (
   input wire logic sys_clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic [1:0] move, // 1 forward, 2 back, 3 jump.
   output logic phaseA, // Phase A pin.
   output logic phaseB // Phase B pin.
);
   logic [1:0] pos_q;
   logic [1:0] pos_d;
   // The phases walk the cycle 00, 01, 11, 10; a jump skips a state so both phases flip.
   always_comb begin
      case (move)
         2'h1: pos_d = pos_q + 2'h1;
         2'h2: pos_d = pos_q - 2'h1;
         2'h3: pos_d = pos_q + 2'h2;
         default: pos_d = pos_q;
      endcase
      phaseA = pos_q[1];
      phaseB = pos_q[1] ^ pos_q[0];
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pos_q <= 2'h0;
      end else begin
         pos_q <= pos_d;
      end
   end
endmodule : quadrature_encoder_model

// ### verif/quadrature_decoder_asserts.sv
`timescale 1ns/100ps
`include "quadrature_decoder_regs.svh"
module quadrature_decoder_asserts (
   input wire logic sys_clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic clkEn, // Clock enable.
   input wire quadrature_decoder_pkg::apbAddr_t paddr, // Address.
   input wire logic psel, // Select.
   input wire logic penable, // Enable.
   input wire logic pwrite, // Direction.
   input wire quadrature_decoder_pkg::word_t pwdata, // Write data.
   input wire quadrature_decoder_pkg::word_t prdata, // Read data.
   input wire logic pready, // Ready.
   input wire logic pslverr, // Error.
   input wire logic phaseA, // Phase A.
   input wire logic phaseB, // Phase B.
   input wire logic ledOut, // LED level.
   input wire logic ledOe, // LED enable.
   input wire logic irq // Interrupt.
);
   import quadrature_decoder_pkg::*;
   logic wrTake;
   logic ledDisc_q;
   logic ledDisc_d;
   logic maskZero_q;
   logic maskZero_d;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Shadow of the LED pin selection and of an all-zero mask, taken from completed writes.
   always_comb begin
      wrTake = psel && penable && pready && pwrite && clkEn;
      ledDisc_d = ledDisc_q;
      maskZero_d = maskZero_q;
      if (wrTake && paddr == `QD_OFS_LEDPIN) begin
         ledDisc_d = pwdata[`QD_LEDPIN_DISC_BIT];
      end
      if (wrTake && paddr == `QD_OFS_INTMASK) begin
         maskZero_d = (pwdata[`QD_EV_W-1:0] == '0);
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ledDisc_q <= `QD_LEDPIN_RST;
         maskZero_q <= 1'b1;
      end else begin
         ledDisc_q <= ledDisc_d;
         maskZero_q <= maskZero_d;
      end
   end
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
   property p_one_wait;
      psel && penable && !pready && clkEn |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("ready late");
   property p_ready_access;
      pready |-> psel && penable;
   endproperty
   a_ready_access: assert property (p_ready_access) else $error("ready outside access");
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_rdata_idle;
      !(pready && !pwrite) |-> prdata == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
   property p_reset_led;
      $fell(rst) |-> !ledOut && !ledOe && !irq;
   endproperty
   a_reset_led: assert property (p_reset_led) else $error("outputs active in reset");
   property p_led_disc;
      ledDisc_q && $past(ledDisc_q) |-> !ledOe;
   endproperty
   a_led_disc: assert property (p_led_disc) else $error("LED pin driven");
   property p_irq_mask;
      maskZero_q && $past(maskZero_q) |-> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
   c_led: cover property ($rose(ledOe));
endmodule : quadrature_decoder_asserts
bind quadrature_decoder quadrature_decoder_asserts u_asserts (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .phaseA(phaseA), .phaseB(phaseB), .ledOut(ledOut), .ledOe(ledOe),
   .irq(irq));

// ### verif/quadrature_decoder_tb.sv
`timescale 1ns/100ps
`include "quadrature_decoder_regs.svh"
module quadrature_decoder_tb;
   import quadrature_decoder_pkg::*;
   logic sys_clk, rst, clkEn, psel, penable, pwrite, pready, pslverr, rerr;
   logic phaseA, phaseB, ledOut, ledOe, irq;
   logic [1:0] move;
   apbAddr_t paddr;
   word_t pwdata, prdata, rdat, stepSeen;
   int fails, checkCount, cycles, ledHigh;
   int expStep [9] = '{1, 1, 1, 1, -1, -1, -1, -1, 2};
   logic [1:0] moves [9] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3};
   quadrature_decoder u_dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .phaseA(phaseA), .phaseB(phaseB), .ledOut(ledOut), .ledOe(ledOe), .irq(irq));
   quadrature_encoder_model u_enc (.sys_clk(sys_clk), .rst(rst), .move(move), .phaseA(phaseA),
      .phaseB(phaseB));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic finish_test();
      if (fails == 0 && checkCount > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input word_t seen, input word_t exp);
      checkCount++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input apbAddr_t a, input word_t wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Outputs read here hold the values sampled at this rising edge.
      do @(posedge sys_clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic stepEncoder(input logic [1:0] m);
      @(posedge sys_clk);
      move <= m;
      @(posedge sys_clk);
      move <= 2'h0;
   endtask : stepEncoder
   task automatic waitSample();
      do @(negedge sys_clk); while (irq !== 1'b1);
      apb(1'b0, `QD_OFS_STEP, '0);
      stepSeen = rdat;
      apb(1'b1, `QD_OFS_EVENTS, 32'h1);
      repeat (2) @(negedge sys_clk);
      chk({31'h0, irq}, 32'h0);
   endtask : waitSample
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 95000) begin
         fails++;
         finish_test();
      end
   end
   initial begin
      rst = 1'b1;
      clkEn = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      move = 2'h0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      apb(1'b0, 12'h200, '0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, '0);
      apb(1'b0, `QD_OFS_LEADTIME, '0);
      chk(rdat, 32'h10);
      apb(1'b0, `QD_OFS_LEDPIN, '0);
      chk(rdat, 32'h80000000);
      apb(1'b1, `QD_OFS_ENABLE, 32'h1);
      apb(1'b1, `QD_OFS_LED_POLARITY, 32'h1);
      apb(1'b1, `QD_OFS_PERIOD, '0);
      apb(1'b1, `QD_OFS_LEDPIN, '0);
      apb(1'b1, `QD_OFS_INTMASK, 32'h1);
      chk({31'h0, ledOe}, 32'h1);
      for (int i = 0; i < 9; i++) begin
         stepEncoder(moves[i]);
         if (i == 0) begin
            apb(1'b1, `QD_OFS_START, 32'h1);
            do @(negedge sys_clk); while (irq !== 1'b1);
            apb(1'b1, `QD_OFS_INTMASK, '0);
            repeat (2) @(negedge sys_clk);
            chk({31'h0, irq}, 32'h0);
            apb(1'b1, `QD_OFS_INTMASK, 32'h1);
            repeat (2) @(negedge sys_clk);
            chk({31'h0, irq}, 32'h1);
         end
         if (i == 1) begin
            // Lead time 16 us at 100 cycles per microsecond: LED active for 1600 cycles before the sample.
            do @(posedge sys_clk); while (ledOut !== 1'b1);
            ledHigh = 0;
            do begin
               @(posedge sys_clk);
               ledHigh++;
            end while (ledOut === 1'b1);
            chk(word_t'(ledHigh), 32'd1600);
         end
         waitSample();
         chk(stepSeen, word_t'(expStep[i]));
         chk({31'h0, ledOut}, 32'h0);
      end
      apb(1'b0, `QD_OFS_TOTAL, '0);
      chk(rdat, '0);
      apb(1'b0, `QD_OFS_DBLCNT, '0);
      chk(rdat, 32'h1);
      apb(1'b1, `QD_OFS_STOP, 32'h1);
      do apb(1'b0, `QD_OFS_EVENTS, '0); while (rdat[`QD_EV_STOPPED] !== 1'b1);
      apb(1'b1, `QD_OFS_EVENTS, 32'h1f);
      apb(1'b1, `QD_OFS_DEBOUNCE, 32'h1);
      apb(1'b1, `QD_OFS_START, 32'h1);
      waitSample();
      chk({31'h0, ledOut}, 32'h1);
      stepEncoder(2'h1);
      waitSample();
      chk(stepSeen, '0);
      waitSample();
      chk(stepSeen, 32'h1);
      waitSample();
      chk(stepSeen, '0);
      finish_test();
   end
endmodule : quadrature_decoder_tb
